// File: rtl/dual_general_io_port.sv
// Top: Avalon-MM register slave for two eight-pin I/O ports
//
// Function
// [R1] Input mode: data read returns synchronised pin level.
// [R2] Output mode: data read returns stored register bit.
// [R3] Output mode: written data bit sets driven pin level.
// [R4] Mode 00 is input, and the reset default.
// [R5] Mode 01 hands the pin to alternate function one.
// [R6] Mode 10 is output driven from the data bit.
// [R7] Mode 11 hands the pin to alternate function two.
// [R8] Mode register: two bits per pin, pin 7 at bits 15-14.
// [R9] Data register: bit n is pin n, upper byte unused.
// [R10] Port A mode register resets to zero.
// [R11] Port A data register resets to zero, read/write.
// [R12] Port B identical to A at its own offsets.
// [R13] Software configures every pin's mode after reset.
// [R14] Software never selects function two on port B pins 6-4.
// [R15] Upper data bits read zero; alternate modes own their pins.
`timescale 1ns/10ps
module dual_general_io_port (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic [17:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	input wire logic [3:0] byteenable,
	output logic [31:0] readdata,
	output logic waitrequest,
	input wire logic [7:0] ioPortAPinsIn,
	output logic [7:0] ioPortAPinsOut,
	output logic [7:0] ioPortAPinsOe,
	input wire logic [7:0] ioPortBPinsIn,
	output logic [7:0] ioPortBPinsOut,
	output logic [7:0] ioPortBPinsOe,
	input wire logic [7:0] portAAlt1Out,
	input wire logic [7:0] portAAlt1Oe,
	input wire logic [7:0] portAAlt2Out,
	input wire logic [7:0] portAAlt2Oe,
	input wire logic [7:0] portBAlt1Out,
	input wire logic [7:0] portBAlt1Oe,
	input wire logic [7:0] portBAlt2Out,
	input wire logic [7:0] portBAlt2Oe,
	output logic [7:0] portAAlt1Sel,
	output logic [7:0] portAAlt2Sel,
	output logic [7:0] portBAlt1Sel,
	output logic [7:0] portBAlt2Sel
);

	// --------------------------------------------------------------
	// Bus handshake
	// --------------------------------------------------------------
	// One wait state: the access is answered one cycle after it is
	// presented, so read data always come from a flip-flop.
	typedef enum logic [1:0] {
		S_IDLE = 2'h1,
		S_DONE = 2'h2
	} bus_state_t;

	bus_state_t state_q;
	logic [31:0] rdata_q;
	logic [15:0] wrData;
	logic [15:0] aDataRd, aModeRd, bDataRd, bModeRd;
	logic [15:0] index;
	logic hitAData, hitAMode, hitBData, hitBMode, lowLanes;
	logic accept, doWrite;

	assign index = address[17:gpio_port_pkg::BYTE_SHIFT];
	assign hitAData = (index == gpio_port_pkg::PORT_A_PIN_DATA_IDX);
	assign hitAMode = (index == gpio_port_pkg::PORT_A_PIN_MODE_SELECT_IDX);
	assign hitBData = (index == gpio_port_pkg::PORT_B_PIN_DATA_IDX); // see [R12]
	assign hitBMode = (index == gpio_port_pkg::PORT_B_PIN_MODE_SELECT_IDX); // see [R12]

	// Registers are 16 bits; both low lanes must be enabled to write.
	// Partial writes are dropped rather than merged, keeping fields whole.
	assign lowLanes = (byteenable[1:0] == 2'h3);
	assign accept = (state_q == S_IDLE) && (read || write);
	// Write lands at the edge where the master sees waitrequest low
	assign doWrite = (state_q == S_DONE) && write && lowLanes;
	assign wrData = writedata[15:0];
	assign waitrequest = !(state_q == S_DONE);

	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			state_q <= S_IDLE;
		end else begin
			case (state_q)
				S_IDLE: begin
					if (read || write) state_q <= S_DONE;
				end
				S_DONE: begin
					state_q <= S_IDLE;
				end
				default: begin
					state_q <= S_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			rdata_q <= gpio_port_pkg::UNMAPPED_READ;
		end else if (accept && read) begin
			if (hitAData) rdata_q <= {16'h0000, aDataRd}; // see [R9] see [R15]
			else if (hitAMode) rdata_q <= {16'h0000, aModeRd};
			else if (hitBData) rdata_q <= {16'h0000, bDataRd};
			else if (hitBMode) rdata_q <= {16'h0000, bModeRd};
			else rdata_q <= gpio_port_pkg::UNMAPPED_READ;
		end
	end

	assign readdata = rdata_q;

	// --------------------------------------------------------------
	// Ports
	// --------------------------------------------------------------
	io_port #(.PINS(gpio_port_pkg::PINS)) u_port_a (
		.ref_clk(ref_clk),
		.nrst(nrst),
		.dataWr(doWrite && hitAData),
		.modeWr(doWrite && hitAMode),
		.wrData(wrData),
		.pinIn(ioPortAPinsIn),
		.alt1Out(portAAlt1Out),
		.alt1Oe(portAAlt1Oe),
		.alt2Out(portAAlt2Out),
		.alt2Oe(portAAlt2Oe),
		.dataRd(aDataRd),
		.modeRd(aModeRd),
		.pinOut(ioPortAPinsOut),
		.pinOe(ioPortAPinsOe),
		.alt1Sel(portAAlt1Sel),
		.alt2Sel(portAAlt2Sel)
	);

	io_port #(.PINS(gpio_port_pkg::PINS)) u_port_b (
		.ref_clk(ref_clk),
		.nrst(nrst),
		.dataWr(doWrite && hitBData),
		.modeWr(doWrite && hitBMode),
		.wrData(wrData),
		.pinIn(ioPortBPinsIn),
		.alt1Out(portBAlt1Out),
		.alt1Oe(portBAlt1Oe),
		.alt2Out(portBAlt2Out),
		.alt2Oe(portBAlt2Oe),
		.dataRd(bDataRd),
		.modeRd(bModeRd),
		.pinOut(ioPortBPinsOut),
		.pinOe(ioPortBPinsOe),
		.alt1Sel(portBAlt1Sel),
		.alt2Sel(portBAlt2Sel)
	);

	// --------------------------------------------------------------
	// Checks
	// --------------------------------------------------------------
	wait_one_a: assert property (@(posedge ref_clk) disable iff (!nrst) // see [R11]
		(waitrequest && (read || write)) |=> !waitrequest)
		else $error("access not answered after one wait state");
	reset_mode_a: assert property (@(posedge ref_clk) // see [R10] see [R12]
		$rose(nrst) |-> (aModeRd == 16'h0000 && bModeRd == 16'h0000))
		else $error("mode register not zero after reset");
	reset_oe_a: assert property (@(posedge ref_clk) // see [R4]
		$rose(nrst) |-> (ioPortAPinsOe == 8'h00 && ioPortBPinsOe == 8'h00))
		else $error("pin driven right after reset");
	upper_zero_a: assert property (@(posedge ref_clk) disable iff (!nrst) // see [R15]
		(accept && read && (hitAData || hitBData)) |=> (readdata[31:8] == 24'h000000))
		else $error("unused data bits not zero");
	write_out_a: assert property (@(posedge ref_clk) disable iff (!nrst) // see [R3] see [R12]
		(doWrite && hitBData && bModeRd[15:14] == 2'h2) |=>
		(ioPortBPinsOut[7] == $past(writedata[7])))
		else $error("port b output level not updated");
	alt_sel_a: assert property (@(posedge ref_clk) disable iff (!nrst) // see [R7]
		(aModeRd[1:0] == 2'h3) |-> (portAAlt2Sel[0] && !portAAlt1Sel[0]))
		else $error("alternate two not selected");
	unmapped_zero_a: assert property (@(posedge ref_clk) disable iff (!nrst) // see [R9]
		(accept && read && !(hitAData || hitAMode || hitBData || hitBMode)) |=>
		(readdata == gpio_port_pkg::UNMAPPED_READ))
		else $error("unmapped read not zero");
	part_drop_a: assert property (@(posedge ref_clk) disable iff (!nrst) // see [R8]
		(!waitrequest && write && !lowLanes) |=>
		($stable(aModeRd) && $stable(bModeRd)))
		else $error("partial write changed a mode register");
	mode_read_a: assert property (@(posedge ref_clk) disable iff (!nrst) // see [R8] see [R12]
		(accept && read && hitBMode) |=> (readdata[15:0] == $past(bModeRd)))
		else $error("mode read data not registered");
	alt_oe_a: assert property (@(posedge ref_clk) disable iff (!nrst) // see [R5]
		(bModeRd[11:10] == 2'h1) |-> (ioPortBPinsOe[5] == portBAlt1Oe[5]))
		else $error("alternate one not driving its pin");

endmodule

// File: include/gpio_port_pkg.sv
// Package: register map, field layout and mode encodings of the dual I/O port
package gpio_port_pkg;

	localparam int PINS = 8;
	localparam int MODE_W = 2;
	localparam int ADDR_W = 16;
	localparam int DATA_W = 32;

	// Printed offsets are not all multiples of four: they are indices, byte address = 4 * index
	localparam logic [ADDR_W-1:0] PORT_A_PIN_DATA_IDX = 16'h0c00;
	localparam logic [ADDR_W-1:0] PORT_A_PIN_MODE_SELECT_IDX = 16'h0c02;
	localparam logic [ADDR_W-1:0] PORT_B_PIN_DATA_IDX = 16'h0c04;
	localparam logic [ADDR_W-1:0] PORT_B_PIN_MODE_SELECT_IDX = 16'h0c06;
	localparam int BYTE_SHIFT = 2;

	localparam logic [15:0] DATA_RESET = 16'h0000;
	localparam logic [15:0] MODE_RESET = 16'h0000;
	localparam logic [DATA_W-1:0] UNMAPPED_READ = 32'h0000_0000;

	typedef enum logic [1:0] {
		MODE_INPUT = 2'h0,
		MODE_ALT1 = 2'h1,
		MODE_OUTPUT = 2'h2,
		MODE_ALT2 = 2'h3
	} pin_mode_t;

endpackage

// File: rtl/pin_sync.sv
// Two-stage synchroniser for a bank of pin inputs
`timescale 1ns/10ps
module pin_sync #(
	parameter int W = 8
) (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic [W-1:0] asyncIn,
	output logic [W-1:0] syncOut
);

	logic [W-1:0] stage1_q;

	// First stage feeds only the second
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			stage1_q <= '0;
			syncOut <= '0;
		end else begin
			stage1_q <= asyncIn;
			syncOut <= stage1_q;
		end
	end

endmodule

// File: rtl/io_port.sv
// One eight-pin port: data and mode registers plus per-pin mux
`timescale 1ns/10ps
module io_port #(
	parameter int PINS = 8
) (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic dataWr,
	input wire logic modeWr,
	input wire logic [15:0] wrData,
	input wire logic [PINS-1:0] pinIn,
	input wire logic [PINS-1:0] alt1Out,
	input wire logic [PINS-1:0] alt1Oe,
	input wire logic [PINS-1:0] alt2Out,
	input wire logic [PINS-1:0] alt2Oe,
	output logic [15:0] dataRd,
	output logic [15:0] modeRd,
	output logic [PINS-1:0] pinOut,
	output logic [PINS-1:0] pinOe,
	output logic [PINS-1:0] alt1Sel,
	output logic [PINS-1:0] alt2Sel
);

	// Mode field packing and data lane map are fixed at eight pins
	if (PINS != 8) begin : g_bad_pins
		$error("io_port supports eight pins only");
	end

	logic [PINS-1:0] data_q;
	logic [2*PINS-1:0] mode_q;
	logic [PINS-1:0] syncIn;

	pin_sync #(.W(PINS)) u_sync (
		.ref_clk(ref_clk),
		.nrst(nrst),
		.asyncIn(pinIn),
		.syncOut(syncIn)
	);

	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			data_q <= gpio_port_pkg::DATA_RESET[PINS-1:0]; // see [R11]
		end else if (dataWr) begin
			data_q <= wrData[PINS-1:0]; // see [R3] see [R15]
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			mode_q <= gpio_port_pkg::MODE_RESET; // see [R4] see [R10]
		end else if (modeWr) begin
			mode_q <= wrData; // see [R8]
		end
	end

	assign modeRd = mode_q;

	always_comb begin
		dataRd = '0; // see [R9]
		pinOut = '0;
		pinOe = '0;
		alt1Sel = '0;
		alt2Sel = '0;
		for (int i = 0; i < PINS; i++) begin
			case (gpio_port_pkg::pin_mode_t'(mode_q[2*i +: 2]))
				gpio_port_pkg::MODE_OUTPUT: begin
					dataRd[i] = data_q[i]; // see [R2]
					pinOut[i] = data_q[i]; // see [R6] see [R3]
					pinOe[i] = 1'b1;
				end
				gpio_port_pkg::MODE_ALT1: begin
					alt1Sel[i] = 1'b1; // see [R5] see [R15]
					pinOut[i] = alt1Out[i];
					pinOe[i] = alt1Oe[i];
					dataRd[i] = syncIn[i];
				end
				gpio_port_pkg::MODE_ALT2: begin
					alt2Sel[i] = 1'b1; // see [R7] see [R15]
					pinOut[i] = alt2Out[i];
					pinOe[i] = alt2Oe[i];
					dataRd[i] = syncIn[i];
				end
				default: begin
					dataRd[i] = syncIn[i]; // see [R1] see [R4]
				end
			endcase
		end
	end

	// --------------------------------------------------------------
	// Checks
	// --------------------------------------------------------------
	out_drive_a: assert property (@(posedge ref_clk) disable iff (!nrst) // see [R6]
		(mode_q[1:0] == 2'h2) |-> (pinOe[0] && pinOut[0] == data_q[0]))
		else $error("output pin not driven from data bit");
	in_float_a: assert property (@(posedge ref_clk) disable iff (!nrst) // see [R1]
		(mode_q[3:2] == 2'h0) |-> (!pinOe[1] && dataRd[1] == syncIn[1]))
		else $error("input pin driven or misread");
	mode_hold_a: assert property (@(posedge ref_clk) disable iff (!nrst) // see [R8]
		(!modeWr) |=> (mode_q == $past(mode_q)))
		else $error("mode changed without write");

endmodule

// File: tb/board_model.sv
// Board side of one port: pin wires, external drivers, alternate sources
`timescale 1ns/10ps
module board_model (
	input wire logic ref_clk,
	input wire logic [7:0] pinsOut,
	input wire logic [7:0] pinsOe,
	input wire logic [7:0] extLvl,
	input wire logic [7:0] extEn,
	output logic [7:0] pinsIn,
	output logic [7:0] alt1Out,
	output logic [7:0] alt1Oe,
	output logic [7:0] alt2Out,
	output logic [7:0] alt2Oe
);
	logic [7:0] last_q = 8'h00;
	logic [7:0] cnt_q = 8'h00;
	// Undriven wire toggles, so a stale level never reads back as valid
	always_ff @(posedge ref_clk) begin
		last_q <= ~pinsIn;
		cnt_q <= cnt_q + 8'h01;
	end
	assign pinsIn = (pinsOe & pinsOut) | (~pinsOe & ((extEn & extLvl) | (~extEn & last_q)));
	// Alternate sources move every cycle to expose a stuck mux
	assign alt1Out = cnt_q;
	assign alt1Oe = cnt_q ^ 8'h55;
	assign alt2Out = ~cnt_q;
	assign alt2Oe = cnt_q ^ 8'haa;
endmodule

// File: tb/dual_general_io_port_test.sv
// Self-checking bench for the dual I/O port
`timescale 1ns/10ps
module dual_general_io_port_test;
	logic ref_clk = 1'b0;
	logic nrst = 1'b0;
	logic [17:0] address = 18'h00000;
	logic read = 1'b0;
	logic write = 1'b0;
	logic [31:0] writedata = 32'h0000_0000;
	logic [3:0] byteenable = 4'h0;
	logic [31:0] readdata;
	logic waitrequest;
	logic [7:0] pIn [2];
	logic [7:0] pOut [2];
	logic [7:0] pOe [2];
	logic [7:0] a1o [2];
	logic [7:0] a1e [2];
	logic [7:0] a2o [2];
	logic [7:0] a2e [2];
	logic [7:0] a1s [2];
	logic [7:0] a2s [2];
	logic [7:0] extLvl [2] = '{8'h00, 8'h00};
	logic [7:0] extEn [2] = '{8'hff, 8'hff};
	int checks = 0;
	int fails = 0;
	int cyc = 0;
	always #4 ref_clk = ~ref_clk;
	dual_general_io_port i_dut (.ref_clk(ref_clk), .nrst(nrst), .address(address), .read(read),
		.write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
		.waitrequest(waitrequest), .ioPortAPinsIn(pIn[0]), .ioPortAPinsOut(pOut[0]),
		.ioPortAPinsOe(pOe[0]), .ioPortBPinsIn(pIn[1]), .ioPortBPinsOut(pOut[1]),
		.ioPortBPinsOe(pOe[1]), .portAAlt1Out(a1o[0]), .portAAlt1Oe(a1e[0]),
		.portAAlt2Out(a2o[0]), .portAAlt2Oe(a2e[0]), .portBAlt1Out(a1o[1]), .portBAlt1Oe(a1e[1]),
		.portBAlt2Out(a2o[1]), .portBAlt2Oe(a2e[1]), .portAAlt1Sel(a1s[0]),
		.portAAlt2Sel(a2s[0]), .portBAlt1Sel(a1s[1]), .portBAlt2Sel(a2s[1]));
	for (genvar p = 0; p < 2; p++) begin : g_board
		board_model i_board (.ref_clk(ref_clk), .pinsOut(pOut[p]), .pinsOe(pOe[p]),
			.extLvl(extLvl[p]), .extEn(extEn[p]), .pinsIn(pIn[p]), .alt1Out(a1o[p]),
			.alt1Oe(a1e[p]), .alt2Out(a2o[p]), .alt2Oe(a2e[p]));
	end
	task automatic summarize;
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 5000) begin
			fails++;
			summarize();
		end
	end
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			fails++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// Entered just after a rising edge; waitrequest and readdata taken at rising edges
	task automatic bus(input logic wr, input logic [17:0] a, input logic [15:0] d,
		input logic [3:0] be, output logic [15:0] q);
		address <= a;
		read <= !wr;
		write <= wr;
		writedata <= {16'h0000, d};
		byteenable <= be;
		@(posedge ref_clk);
		while (waitrequest !== 1'b0) @(posedge ref_clk);
		q = readdata[15:0];
		read <= 1'b0;
		write <= 1'b0;
		// Idle edge keeps back-to-back calls from reassigning the strobes
		@(posedge ref_clk);
	endtask
	function automatic logic [15:0] expPin(input logic [15:0] m, input logic [7:0] dat,
		input logic [7:0] o1, input logic [7:0] e1, input logic [7:0] o2, input logic [7:0] e2);
		logic [7:0] o;
		logic [7:0] e;
		for (int i = 0; i < 8; i++) begin
			case (m[2*i+:2])
				2'h1: {e[i], o[i]} = {e1[i], o1[i]};
				2'h2: {e[i], o[i]} = {1'b1, dat[i]};
				2'h3: {e[i], o[i]} = {e2[i], o2[i]};
				default: {e[i], o[i]} = 2'b00;
			endcase
		end
		return {e, o & e};
	endfunction
	task automatic resetTest;
		logic [15:0] q;
		bus(1'b1, 18'h03020, 16'hffff, 4'hf, q);
		bus(1'b0, 18'h03020, 16'h0000, 4'hf, q);
		check(q, 16'h0000);
		for (int r = 0; r < 4; r++) begin
			bus(1'b0, 18'h03000 + 18'(r * 8), 16'h0000, 4'hf, q);
			check(q, 16'h0000);
		end
		check({pOe[0], pOe[1]}, 16'h0000);
		// Output mode exposes stored data bits, still at reset value
		bus(1'b1, 18'h03008, 16'haaaa, 4'hf, q);
		bus(1'b0, 18'h03000, 16'h0000, 4'hf, q);
		check(q, 16'h0000);
		check({pOe[0], pOut[0]}, 16'hff00);
		bus(1'b1, 18'h03008, 16'h0000, 4'hf, q);
		$display("reset test done");
	endtask
	task automatic midResetTest;
		logic [15:0] q;
		nrst <= 1'b0;
		repeat (10) @(posedge ref_clk);
		nrst <= 1'b1;
		@(posedge ref_clk);
		bus(1'b0, 18'h03008, 16'h0000, 4'hf, q);
		check(q, 16'h0000);
		bus(1'b0, 18'h03018, 16'h0000, 4'hf, q);
		check(q, 16'h0000);
		check({pOe[0], pOe[1]}, 16'h0000);
		check({a1s[1], a2s[1]}, 16'h0000);
		bus(1'b1, 18'h03018, 16'haaaa, 4'hf, q);
		bus(1'b0, 18'h03010, 16'h0000, 4'hf, q);
		check(q, 16'h0000);
		$display("mid-run reset test done");
	endtask
	task automatic portTest(input int p);
		logic [17:0] b;
		logic [15:0] q;
		logic [7:0] lv;
		b = 18'h03000 + 18'(p * 16);
		lv = 8'ha5 ^ 8'(p);
		extLvl[p] <= lv;
		extEn[p] <= 8'hff;
		repeat (4) @(posedge ref_clk);
		bus(1'b0, b, 16'h0000, 4'hf, q);
		check(q, {8'h00, lv});
		extEn[p] <= 8'h00;
		bus(1'b1, b + 18'h8, 16'haaaa, 4'hf, q);
		// Partial-lane mode write must be dropped
		bus(1'b1, b + 18'h8, 16'h0000, 4'h2, q);
		bus(1'b1, b, 16'hff96, 4'hf, q);
		bus(1'b1, b, 16'h0011, 4'h1, q);
		bus(1'b0, b, 16'h0000, 4'hf, q);
		check(q, 16'h0096);
		check({pOe[p], pOut[p]}, 16'hff96);
		// Pins 6-4 avoid function two on either port
		bus(1'b1, b + 18'h8, 16'he41b, 4'hf, q);
		bus(1'b0, b + 18'h8, 16'h0000, 4'hf, q);
		check(q, 16'he41b);
		@(negedge ref_clk);
		check({a1s[p], a2s[p]}, 16'h2481);
		check({pOe[p], pOut[p] & pOe[p]},
			expPin(16'he41b, 8'h96, a1o[p], a1e[p], a2o[p], a2e[p]));
		@(posedge ref_clk);
		$display("port %0d test done", p);
	endtask
	initial begin
		repeat (10) @(posedge ref_clk);
		nrst <= 1'b1;
		@(posedge ref_clk);
		resetTest();
		portTest(0);
		portTest(1);
		midResetTest();
		summarize();
	end
endmodule
